// *** common/arpm_regs.svh ***
// arpm_regs.svh: address map, field positions, codes and reset values of the
// process-data words of the analog input, analog output and relay modules.
// assumes byte addresses on the process-data port, words at even addresses.
`ifndef ARPM_REGS_SVH
`define ARPM_REGS_SVH

// ----------------------------------------------------------------------------
// address map
// ----------------------------------------------------------------------------
`define ARPM_AW              10
`define ARPM_CH_STEP         2
`define ARPM_WIN_BYTES       8
`define ARPM_PI_LAST_BYTE    10'h07F
`define ARPM_AI_GAIN_BASE    10'h08C
`define ARPM_AI_VALUE_BASE   10'h084
`define ARPM_AO_BASE         10'h0A0
`define ARPM_RELAY_BASE      10'h010

// ----------------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------------
`define ARPM_GAIN_HI         15
`define ARPM_GAIN_LO         14
`define ARPM_VALUE_MSB       11
`define ARPM_BYTE_N_HI       15
`define ARPM_BYTE_N_LO       8
`define ARPM_BYTE_M_HI       7
`define ARPM_BYTE_M_LO       0

// ----------------------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------------------
`define ARPM_GAIN_1          2'h0
`define ARPM_GAIN_10         2'h1
`define ARPM_GAIN_100        2'h2
`define ARPM_GAIN_BAD        2'h3
`define ARPM_GAIN_RST        2'h0
`define ARPM_WORD_RST        16'h0000
`define ARPM_CODE_RST        12'h000
`define ARPM_BYTE_RST        8'h00

`endif

// *** common/arpm_pkg.sv ***
// arpm_pkg: types shared by the process-map block and its channel modules.
// assumes arpm_regs.svh is on the include path.
package arpm_pkg;

  // ----------------------------------------------------------------------------
  // coding of the 12-bit analog value, fixed per module variant
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ARPM_BINARY = 2'h1,
    ARPM_TWOS   = 2'h2
  } arpm_coding_t;

  // ----------------------------------------------------------------------------
  // process-data answer state, one-hot
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ARPM_IDLE   = 2'h1,
    ARPM_ANSWER = 2'h2
  } arpm_ans_t;

endpackage : arpm_pkg

// *** core/arpm_ai_chan.sv ***
// arpm_ai_chan: one analog input channel, gain word decode and value word.
// assumes the converter delivers offset-binary codes on mclk with a strobe.
`timescale 1ns/10ps
`include "arpm_regs.svh"
module arpm_ai_chan
  import arpm_pkg::*;
#(
  parameter arpm_coding_t CODING = ARPM_BINARY
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // gain word from the controller
  input  wire logic        gain_we,
  input  wire logic [15:0] gain_word,
  // converter side
  input  wire logic        conv_valid,
  input  wire logic [11:0] conv_raw,
  output logic      [1:0]  gain_sel_q,
  output logic             gain_bad_q,
  output logic      [15:0] value_q
);
  logic [1:0]  gain_field;
  logic [11:0] code_d;

  // only the top two bits matter, the rest of the word is dropped here
  assign gain_field = gain_word[`ARPM_GAIN_HI:`ARPM_GAIN_LO];

  always_ff @(posedge mclk) begin
    if (srst) begin
      gain_sel_q <= `ARPM_GAIN_RST;
      gain_bad_q <= 1'b0;
    end else if (gain_we) begin
      gain_bad_q <= (gain_field == `ARPM_GAIN_BAD);
      // the invalid code keeps the gain in force
      if (gain_field != `ARPM_GAIN_BAD) begin
        gain_sel_q <= gain_field;
      end
    end
  end

  // two's complement is offset binary with the top bit inverted
  assign code_d = (CODING == ARPM_TWOS) ?
                  {~conv_raw[`ARPM_VALUE_MSB], conv_raw[`ARPM_VALUE_MSB-1:0]} :
                  conv_raw;

  always_ff @(posedge mclk) begin
    if (srst) begin
      value_q <= `ARPM_WORD_RST;
    end else if (conv_valid) begin
      value_q <= (CODING == ARPM_TWOS) ? {{4{code_d[`ARPM_VALUE_MSB]}}, code_d} :
                 {4'h0, code_d};
    end
  end

endmodule : arpm_ai_chan

// *** core/arpm_ao_chan.sv ***
// arpm_ao_chan: one analog output channel, value word to converter code.
// assumes an offset-binary converter behind the channel on mclk.
`timescale 1ns/10ps
`include "arpm_regs.svh"
module arpm_ao_chan
  import arpm_pkg::*;
#(
  parameter arpm_coding_t CODING = ARPM_BINARY
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // value word from the controller
  input  wire logic        out_we,
  input  wire logic [15:0] out_word,
  // converter side
  output logic      [11:0] dac_code_q
);
  logic [11:0] val;

  assign val = out_word[`ARPM_VALUE_MSB:0];

  always_ff @(posedge mclk) begin
    if (srst) begin
      dac_code_q <= `ARPM_CODE_RST;
    end else if (out_we) begin
      // null of a bipolar channel lands at mid-scale of the converter
      dac_code_q <= (CODING == ARPM_TWOS) ?
                    {~val[`ARPM_VALUE_MSB], val[`ARPM_VALUE_MSB-1:0]} : val;
    end
  end

endmodule : arpm_ao_chan

// *** core/arpm_process_map.sv ***
// arpm_process_map: process-data words of a four-channel analog input module,
// a four-channel analog output module and a relay module on one station.
// assumes one controller port on mclk; converters and relays are same-clock logic.
`timescale 1ns/10ps
`include "arpm_regs.svh"
module arpm_process_map
  import arpm_pkg::*;
#(
  parameter int                AW          = `ARPM_AW,
  parameter arpm_coding_t      AI_CODING   = ARPM_BINARY,
  parameter arpm_coding_t      AO_CODING   = ARPM_BINARY,
  parameter logic [`ARPM_AW-1:0] AI_GAIN_BASE  = `ARPM_AI_GAIN_BASE,
  parameter logic [`ARPM_AW-1:0] AI_VALUE_BASE = `ARPM_AI_VALUE_BASE,
  parameter logic [`ARPM_AW-1:0] AO_BASE       = `ARPM_AO_BASE,
  parameter logic [`ARPM_AW-1:0] RELAY_BASE    = `ARPM_RELAY_BASE
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          srst,
  // process-data port from the controller
  input  wire logic          pd_wr,
  input  wire logic          pd_rd,
  input  wire logic          pd_area_out,
  input  wire logic [AW-1:0] pd_addr,
  input  wire logic [1:0]    pd_be,
  input  wire logic [15:0]   pd_wdata,
  output logic      [15:0]   pd_rdata_q,
  output logic               pd_rack_q,
  output logic               pd_err_q,
  // analog input converters and amplifiers
  input  wire logic [3:0]    ai_conv_valid,
  input  wire logic [47:0]   ai_conv_raw,
  output logic      [7:0]    ai_gain_sel_q,
  output logic      [3:0]    ai_gain_bad_q,
  // analog output converters
  output logic      [47:0]   ao_dac_code_q,
  // relay drivers
  output logic      [7:0]    relay_base_q,
  output logic      [7:0]    relay_exp_q
);

  // ----------------------------------------------------------------------------
  // address windows
  // ----------------------------------------------------------------------------
  localparam logic [AW-1:0] WIN_BYTES = AW'(`ARPM_WIN_BYTES);
  localparam logic [AW-1:0] PI_LAST   = AW'(`ARPM_PI_LAST_BYTE);

  // returns {hit, channel}; only even word addresses inside the window hit
  function automatic logic [2:0] win_hit(input logic [AW-1:0] addr,
                                         input logic [AW-1:0] base);
    logic [AW-1:0] off;
    off = addr - base;
    win_hit = {(addr >= base) && (off < WIN_BYTES) && !off[0],
               off[2:1]};
  endfunction : win_hit

  logic [2:0]  gain_hit;
  logic [2:0]  value_hit;
  logic [2:0]  ao_hit;
  logic        relay_hit;
  logic        relay_hit_odd;
  logic        wr_out;
  logic        rd_in;
  logic        wr_any_hit;
  logic        rd_any_hit;

  // gain words live in the output area, value words in the input area
  assign gain_hit  = win_hit(pd_addr, AI_GAIN_BASE);
  assign value_hit = win_hit(pd_addr, AI_VALUE_BASE);
  // the output module has no input window at all
  assign ao_hit    = win_hit(pd_addr, AO_BASE);

  // relay word: byte n at the even base, byte n+1 right after it
  assign relay_hit     = (pd_addr == RELAY_BASE) && (pd_addr <= PI_LAST);
  assign relay_hit_odd = (pd_addr == RELAY_BASE + AW'(1)) &&
                         (pd_addr <= PI_LAST);

  assign wr_out = pd_wr && pd_area_out;
  assign rd_in  = pd_rd && !pd_area_out;

  assign wr_any_hit = gain_hit[2] || ao_hit[2] || relay_hit || relay_hit_odd;
  assign rd_any_hit = value_hit[2];

  // ----------------------------------------------------------------------------
  // analog input channels
  // ----------------------------------------------------------------------------
  logic [3:0]  gain_we;
  logic [15:0] ai_value [4];
  logic [1:0]  ai_sel   [4];
  logic [3:0]  ai_bad;

  generate
    for (genvar c = 0; c < 4; c++) begin : g_ai
      // a gain word is taken only as a whole word
      assign gain_we[c] = wr_out && gain_hit[2] && (gain_hit[1:0] == 2'(c)) &&
                          (&pd_be);

      arpm_ai_chan #(
        .CODING     (AI_CODING)
      ) u_ai (
        .mclk       (mclk),
        .srst       (srst),
        .gain_we    (gain_we[c]),
        .gain_word  (pd_wdata),
        .conv_valid (ai_conv_valid[c]),
        .conv_raw   (ai_conv_raw[12*c +: 12]),
        .gain_sel_q (ai_sel[c]),
        .gain_bad_q (ai_bad[c]),
        .value_q    (ai_value[c])
      );

      assign ai_gain_sel_q[2*c +: 2] = ai_sel[c];
      assign ai_gain_bad_q[c]        = ai_bad[c];
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // analog output channels
  // ----------------------------------------------------------------------------
  logic [3:0]  ao_we;
  logic [11:0] ao_code [4];

  generate
    for (genvar c = 0; c < 4; c++) begin : g_ao
      assign ao_we[c] = wr_out && ao_hit[2] && (ao_hit[1:0] == 2'(c)) &&
                        (&pd_be);

      arpm_ao_chan #(
        .CODING     (AO_CODING)
      ) u_ao (
        .mclk       (mclk),
        .srst       (srst),
        .out_we     (ao_we[c]),
        .out_word   (pd_wdata),
        .dac_code_q (ao_code[c])
      );

      assign ao_dac_code_q[12*c +: 12] = ao_code[c];
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // relay word
  // ----------------------------------------------------------------------------
  logic base_we;
  logic exp_we;
  logic [7:0] base_byte;
  logic [7:0] exp_byte;

  // a word write at n carries byte n high and byte n+1 low; a byte write to
  // n+1 carries its byte in the low lane
  assign base_we   = wr_out && relay_hit && pd_be[1];
  assign exp_we    = wr_out && ((relay_hit && pd_be[0]) || (relay_hit_odd && pd_be[0]));
  assign base_byte = pd_wdata[`ARPM_BYTE_N_HI:`ARPM_BYTE_N_LO];
  assign exp_byte  = pd_wdata[`ARPM_BYTE_M_HI:`ARPM_BYTE_M_LO];

  always_ff @(posedge mclk) begin
    if (srst) begin
      relay_base_q <= `ARPM_BYTE_RST;
    end else if (base_we) begin
      relay_base_q <= base_byte;
    end
  end

  // the second byte is held whether or not an expansion unit is fitted
  always_ff @(posedge mclk) begin
    if (srst) begin
      relay_exp_q <= `ARPM_BYTE_RST;
    end else if (exp_we) begin
      relay_exp_q <= exp_byte;
    end
  end

  // ----------------------------------------------------------------------------
  // read answer
  // ----------------------------------------------------------------------------
  arpm_ans_t   ans_q;
  arpm_ans_t   ans_d;
  logic [15:0] rdata_d;

  // reads are answered one cycle later; a read during an answer is a new one
  always_comb begin
    case (ans_q)
      ARPM_IDLE:   ans_d = pd_rd ? ARPM_ANSWER : ARPM_IDLE;
      ARPM_ANSWER: ans_d = pd_rd ? ARPM_ANSWER : ARPM_IDLE;
      default:     ans_d = ARPM_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ans_q <= ARPM_IDLE;
    end else begin
      ans_q <= ans_d;
    end
  end

  // write-only words and unmapped addresses read as zero
  always_comb begin
    rdata_d = `ARPM_WORD_RST;
    if (rd_in && value_hit[2]) begin
      rdata_d = ai_value[value_hit[1:0]];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pd_rdata_q <= `ARPM_WORD_RST;
      pd_rack_q  <= 1'b0;
    end else begin
      pd_rdata_q <= rdata_d;
      pd_rack_q  <= (ans_d == ARPM_ANSWER);
    end
  end

  // ----------------------------------------------------------------------------
  // access errors
  // ----------------------------------------------------------------------------
  logic err_d;

  // flags a write that hits nothing, a read that hits nothing, a write
  // into the input area or a read from the output area; a flagged write changes no state, a flagged read still raises pd_rack_q with zero data
  always_comb begin
    err_d = 1'b0;
    if (pd_wr && (!pd_area_out || !wr_any_hit)) begin
      err_d = 1'b1;
    end
    if (pd_rd && (pd_area_out || !rd_any_hit)) begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pd_err_q <= 1'b0;
    end else begin
      pd_err_q <= err_d;
    end
  end

endmodule : arpm_process_map

// *** testbench/arpm_process_map_monitor.sv ***
// arpm_process_map_monitor: timing properties of the process-data port.
// assumes one mclk domain; bound to every arpm_process_map instance.
`timescale 1ns/10ps
`include "arpm_regs.svh"
module arpm_process_map_monitor
  import arpm_pkg::*;
#(
  parameter arpm_coding_t        AI_CODING     = ARPM_BINARY,
  parameter arpm_coding_t        AO_CODING     = ARPM_BINARY,
  parameter logic [`ARPM_AW-1:0] AI_GAIN_BASE  = `ARPM_AI_GAIN_BASE,
  parameter logic [`ARPM_AW-1:0] AI_VALUE_BASE = `ARPM_AI_VALUE_BASE,
  parameter logic [`ARPM_AW-1:0] AO_BASE       = `ARPM_AO_BASE,
  parameter logic [`ARPM_AW-1:0] RELAY_BASE    = `ARPM_RELAY_BASE
) (
  // clock and reset
  input wire logic        mclk,
  input wire logic        srst,
  // process-data port
  input wire logic        pd_wr,
  input wire logic        pd_rd,
  input wire logic        pd_area_out,
  input wire logic [9:0]  pd_addr,
  input wire logic [1:0]  pd_be,
  input wire logic [15:0] pd_wdata,
  input wire logic [15:0] pd_rdata_q,
  input wire logic        pd_rack_q,
  input wire logic        pd_err_q,
  // channel and relay outputs
  input wire logic [7:0]  ai_gain_sel_q,
  input wire logic [3:0]  ai_gain_bad_q,
  input wire logic [47:0] ao_dac_code_q,
  input wire logic [7:0]  relay_base_q,
  input wire logic [7:0]  relay_exp_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  wire logic out_wr = pd_wr && pd_area_out && pd_be == 2'h3;
  sequence s_relay_word;
    out_wr && pd_addr == RELAY_BASE;
  endsequence
  sequence s_gain_ok;
    out_wr && pd_addr == AI_GAIN_BASE && pd_wdata[15:14] != `ARPM_GAIN_BAD;
  endsequence
  property p_rack; pd_rd |=> pd_rack_q; endproperty
  a_rack: assert property (p_rack) else $error("read not answered");
  property p_relay_word;
    s_relay_word |=> relay_base_q == $past(pd_wdata[15:8]) && relay_exp_q == $past(pd_wdata[7:0]);
  endproperty
  a_relay_word: assert property (p_relay_word) else $error("relay word lost");
  property p_relay_exp;
    pd_wr && pd_area_out && pd_addr == RELAY_BASE + 10'h1 && pd_be == 2'h1
      |=> relay_exp_q == $past(pd_wdata[7:0]) && $stable(relay_base_q);
  endproperty
  a_relay_exp: assert property (p_relay_exp) else $error("relay byte two wrong");
  property p_gain_ok;
    s_gain_ok |=> ai_gain_sel_q[1:0] == $past(pd_wdata[15:14]) && !ai_gain_bad_q[0];
  endproperty
  a_gain_ok: assert property (p_gain_ok) else $error("gain not applied");
  property p_gain_bad;
    out_wr && pd_addr == AI_GAIN_BASE + 10'h6 && pd_wdata[15:14] == `ARPM_GAIN_BAD
      |=> $stable(ai_gain_sel_q[7:6]) && ai_gain_bad_q[3];
  endproperty
  a_gain_bad: assert property (p_gain_bad) else $error("invalid gain applied");
  property p_ao;
    out_wr && pd_addr == AO_BASE + 10'h6 |=> ao_dac_code_q[47:36] ==
      ($past(pd_wdata[11:0]) ^ (AO_CODING == ARPM_TWOS ? 12'h800 : 12'h000));
  endproperty
  a_ao: assert property (p_ao) else $error("output code wrong");
  property p_sext;
    pd_rd && !pd_area_out && pd_addr == AI_VALUE_BASE + 10'h2 |=> pd_rack_q &&
      pd_rdata_q[15:12] == (AI_CODING == ARPM_TWOS ? {4{pd_rdata_q[11]}} : 4'h0);
  endproperty
  a_sext: assert property (p_sext) else $error("value upper bits wrong");
  property p_ao_no_in; pd_rd && !pd_area_out && pd_addr == AO_BASE |-> ##1 pd_err_q; endproperty
  a_ao_no_in: assert property (p_ao_no_in) else $error("output module read");
  property p_in_wr; pd_wr && !pd_area_out && pd_addr == AI_VALUE_BASE |=> pd_err_q; endproperty
  a_in_wr: assert property (p_in_wr) else $error("input word written");
endmodule : arpm_process_map_monitor
bind arpm_process_map arpm_process_map_monitor #(.AI_CODING(AI_CODING), .AO_CODING(AO_CODING),
  .AI_GAIN_BASE(AI_GAIN_BASE), .AI_VALUE_BASE(AI_VALUE_BASE), .AO_BASE(AO_BASE),
  .RELAY_BASE(RELAY_BASE)) u_mon (.mclk(mclk), .srst(srst), .pd_wr(pd_wr), .pd_rd(pd_rd),
  .pd_area_out(pd_area_out), .pd_addr(pd_addr), .pd_be(pd_be), .pd_wdata(pd_wdata),
  .pd_rdata_q(pd_rdata_q), .pd_rack_q(pd_rack_q), .pd_err_q(pd_err_q),
  .ai_gain_sel_q(ai_gain_sel_q), .ai_gain_bad_q(ai_gain_bad_q), .ao_dac_code_q(ao_dac_code_q),
  .relay_base_q(relay_base_q), .relay_exp_q(relay_exp_q));

// *** testbench/arpm_ctl_model.sv ***
// arpm_ctl_model: controller board side of the process-data port.
// assumes the bench calls xfer; one request per call.
`timescale 1ns/10ps
module arpm_ctl_model (
  // clock and answers
  input wire logic        mclk,
  input wire logic [15:0] pd_rdata_q,
  input wire logic        pd_rack_q,
  input wire logic        pd_err_q,
  // requests
  output logic            pd_wr,
  output logic            pd_rd,
  output logic            pd_area_out,
  output logic [9:0]      pd_addr,
  output logic [1:0]      pd_be,
  output logic [15:0]     pd_wdata
);
  initial begin
    pd_wr = 1'b0;
    pd_rd = 1'b0;
    pd_area_out = 1'b0;
    pd_addr = 10'h000;
    pd_be = 2'h0;
    pd_wdata = 16'h0000;
  end
  task automatic xfer(input logic wr, input logic area, input logic [9:0] addr,
                      input logic [1:0] be, input logic [15:0] wd, input int gap,
                      output logic [15:0] rdat, output logic rack, output logic err);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    pd_wr <= wr;
    pd_rd <= !wr;
    pd_area_out <= area;
    pd_addr <= addr;
    pd_be <= be;
    pd_wdata <= wd;
    @(posedge mclk);
    pd_wr <= 1'b0;
    pd_rd <= 1'b0;
    // released address and data lines show the inverted pattern, never the last value
    pd_addr <= ~addr;
    pd_wdata <= ~wd;
    #1;
    rdat = pd_rdata_q;
    rack = pd_rack_q;
    err = pd_err_q;
  endtask : xfer
endmodule : arpm_ctl_model

// *** testbench/arpm_process_map_tb.sv ***
// arpm_process_map_tb: self-checking bench, both coding variants side by side.
// assumes arpm_regs.svh on the include path.
`timescale 1ns/10ps
`include "arpm_regs.svh"
module arpm_process_map_tb
  import arpm_pkg::*;
;
  localparam logic [9:0] GB = `ARPM_AI_GAIN_BASE; // analog words above the image
  localparam logic [9:0] VB = `ARPM_AI_VALUE_BASE;
  localparam logic [9:0] OB = `ARPM_AO_BASE;
  localparam logic [9:0] RB = `ARPM_RELAY_BASE; // even, inside bytes 0 to 127
  logic mclk = 1'b0, srst = 1'b1, pd_wr, pd_rd, pd_area_out, pd_rack_q, pd_err_q, rack, err;
  logic [9:0] pd_addr;
  logic [1:0] pd_be;
  logic [15:0] pd_wdata, pd_rdata_q, rdat, d, rel_m;
  logic [3:0] ai_conv_valid = 4'h0, ai_gain_bad_q;
  logic [47:0] ai_conv_raw = 48'h0, ao_dac_code_q;
  logic [7:0] ai_gain_sel_q, relay_base_q, relay_exp_q;
  logic [11:0] raw;
  logic [15:0] rdata_b;
  logic [47:0] ao_b;
  int err_count = 0, num_checks = 0, v;
  int gain_m[4], bad_m[4], ao_m[4];
  always #2.5 mclk = ~mclk;
  arpm_process_map #(.AI_CODING(ARPM_TWOS), .AO_CODING(ARPM_BINARY)) u_dut (.mclk(mclk),
    .srst(srst), .pd_wr(pd_wr), .pd_rd(pd_rd), .pd_area_out(pd_area_out), .pd_addr(pd_addr),
    .pd_be(pd_be), .pd_wdata(pd_wdata), .pd_rdata_q(pd_rdata_q), .pd_rack_q(pd_rack_q),
    .pd_err_q(pd_err_q), .ai_conv_valid(ai_conv_valid), .ai_conv_raw(ai_conv_raw),
    .ai_gain_sel_q(ai_gain_sel_q), .ai_gain_bad_q(ai_gain_bad_q),
    .ao_dac_code_q(ao_dac_code_q), .relay_base_q(relay_base_q), .relay_exp_q(relay_exp_q));
  // second variant on the same port: binary input coding, two's output coding
  arpm_process_map #(.AI_CODING(ARPM_BINARY), .AO_CODING(ARPM_TWOS)) u_dut_b (.mclk(mclk),
    .srst(srst), .pd_wr(pd_wr), .pd_rd(pd_rd), .pd_area_out(pd_area_out), .pd_addr(pd_addr),
    .pd_be(pd_be), .pd_wdata(pd_wdata), .pd_rdata_q(rdata_b), .pd_rack_q(), .pd_err_q(),
    .ai_conv_valid(ai_conv_valid), .ai_conv_raw(ai_conv_raw), .ai_gain_sel_q(),
    .ai_gain_bad_q(), .ao_dac_code_q(ao_b), .relay_base_q(), .relay_exp_q());
  arpm_ctl_model u_ctl (.mclk(mclk), .pd_rdata_q(pd_rdata_q), .pd_rack_q(pd_rack_q),
    .pd_err_q(pd_err_q), .pd_wr(pd_wr), .pd_rd(pd_rd), .pd_area_out(pd_area_out),
    .pd_addr(pd_addr), .pd_be(pd_be), .pd_wdata(pd_wdata));
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic acc(input logic w, input logic area, input logic [9:0] a,
                     input logic [1:0] be, input logic [15:0] wd);
    u_ctl.xfer(w, area, a, be, wd, $urandom_range(2), rdat, rack, err);
  endtask : acc
  task automatic chk_all;
    logic [7:0] g;
    logic [3:0] b;
    logic [47:0] o;
    for (int c = 0; c < 4; c++) begin
      g[2*c +: 2] = 2'(gain_m[c]);
      b[c] = 1'(bad_m[c]);
      o[12*c +: 12] = 12'(ao_m[c]);
    end
    chk({ai_gain_sel_q, ai_gain_bad_q}, {g, b});
    chk(ao_dac_code_q, o);
    chk({relay_base_q, relay_exp_q}, rel_m);
  endtask : chk_all
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    test_done;
  end
  initial begin
    void'($urandom(32'hF0E1));
    gain_m = '{default: 0};
    bad_m = '{default: 0};
    ao_m = '{default: 0};
    rel_m = 16'h0000;
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    #1 chk_all;
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 4; k++) begin
        d = {2'(k), 14'($urandom)};
        acc(1'b1, 1'b1, GB + 10'(2 * c), 2'h3, d);
        if (k != 3) gain_m[c] = k;
        bad_m[c] = (k == 3);
        chk_all;
      end
    end
    // channel 1 serves as a current input
    acc(1'b1, 1'b1, GB + 10'h2, 2'h3, 16'h4000);
    gain_m[1] = 1;
    bad_m[1] = 0;
    chk_all;
    acc(1'b1, 1'b1, GB, 2'h2, 16'h4000);
    chk_all;
    for (int c = 0; c < 4; c++) begin
      raw = (c == 0) ? 12'hFFF : (c == 1) ? 12'h000 : 12'($urandom);
      @(posedge mclk);
      ai_conv_valid <= 4'(1 << c);
      ai_conv_raw[12*c +: 12] <= raw;
      @(posedge mclk);
      ai_conv_valid <= 4'h0;
      acc(1'b0, 1'b0, VB + 10'(2 * c), 2'h3, 16'($urandom));
      v = int'(raw ^ 12'h800);
      if (v >= 2048) v -= 4096;
      chk({err, rack, rdat}, {2'h1, 16'(v)});
      chk(rdata_b, {4'h0, raw});
    end
    acc(1'b0, 1'b0, OB, 2'h3, 16'h0000);
    chk({err, rack, rdat}, {2'h3, 16'h0000});
    acc(1'b1, 1'b0, VB, 2'h3, 16'hFFFF);
    chk(err, 1'b1);
    for (int c = 0; c < 4; c++) begin
      d = (c == 0) ? 16'h0FFF : (c == 1) ? 16'h0000 : 16'($urandom);
      acc(1'b1, 1'b1, OB + 10'(2 * c), 2'h3, d);
      ao_m[c] = int'(d[11:0]);
      chk_all;
      chk(ao_b[12*c +: 12], d[11:0] ^ 12'h800);
    end
    for (int k = 0; k < 3; k++) begin
      d = 16'($urandom);
      acc(1'b1, 1'b1, RB, 2'h3, d);
      rel_m = d;
      chk_all;
      acc(1'b1, 1'b1, RB + 10'h1, 2'h1, ~d);
      rel_m[7:0] = ~d[7:0];
      chk_all;
    end
    @(posedge mclk);
    srst <= 1'b1;
    @(posedge mclk);
    srst <= 1'b0;
    gain_m = '{default: 0};
    bad_m = '{default: 0};
    ao_m = '{default: 0};
    rel_m = 16'h0000;
    #1 chk_all;
    test_done;
  end
endmodule : arpm_process_map_tb
